/* core/dalu_top.sv */
// 32-bit ALU and accumulator with store shifters, branch target, normalise and bit test
//
// Function
// RL1 - The ALU and accumulator are 32 bits wide and the accumulator is always the left operand.
// RL2 - The right operand is chosen per instruction between the product holding register and the input shifter.
// RL3 - Each ALU operation writes its result back into the accumulator.
// RL4 - The accumulator is stored as separate high and low 16-bit halves, one store each.
// RL5 - Stores shift the chosen half onto the data bus while the accumulator keeps its value.
// RL6 - Most operations complete in one clock cycle.
// RL7 - The accumulator contents are offered as a branch target address.
// RL8 - A fixed-point value in the accumulator can be normalised.
// RL9 - One selected bit of a data word can be tested to give a branch condition.
// RL10 - The input shifter left-shifts a 16-bit word by 0 to 16 places into 32 bits, zero-filling the low bits.
// RL11 - Upper bits of the shifted value are zero-filled or sign-extended by the sign-extend select bit.
// RL12 - The accumulator changes only on an edge where the sequencer raises its write strobe.
`timescale 1ns/1ps
module dalu_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_acc_write,
  input  wire logic [3:0]  i_op,
  input  wire logic [1:0]  i_src_sel,
  input  wire logic [15:0] i_data_word,
  input  wire logic [4:0]  i_in_shift,
  input  wire logic [31:0] i_product_holding_register,
  input  wire logic [15:0] i_second_status_register,
  input  wire logic        i_store,
  input  wire logic        i_store_high,
  input  wire logic [2:0]  i_out_shift,
  input  wire logic        i_bit_test,
  input  wire logic [3:0]  i_bit_sel,
  output logic      [31:0] o_acc,
  output logic      [15:0] o_branch_target,
  output logic      [15:0] o_store_data,
  output logic             o_store_valid,
  output logic             o_bit_cond,
  output logic             o_bit_cond_valid,
  output logic             o_carry,
  output logic             o_overflow,
  output logic             o_zero,
  output logic             o_negative
);

  // ---------------------------------------------------------------
  // Input shifter
  // ---------------------------------------------------------------
  dalu_shift_if sh_bus ();
  logic         sign_extend_select_bit;

  // Mode bit shared by the input shifter and the right shift
  assign sign_extend_select_bit = i_second_status_register[dalu_pkg::SXM_BIT_POS[3:0]];  // [RL11]
  assign sh_bus.data_word = i_data_word;
  assign sh_bus.shift_amt = i_in_shift;
  assign sh_bus.sign_ext  = sign_extend_select_bit;  // [RL11]

  dalu_in_shifter u_shift (
    .sh (sh_bus.shift)
  );

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Normalise step: shift left once while two top bits agree
  function automatic logic [31:0] norm_step(input logic [31:0] v);
    if (v != 32'h0000_0000 && v[31] == v[30]) begin
      norm_step = {v[30:0], 1'b0};
    end else begin
      norm_step = v;
    end
  endfunction

  function automatic logic is_zero(input logic [31:0] v);
    is_zero = (v == 32'h0000_0000);
  endfunction

  // Two's complement negation, shared by negate and absolute value
  function automatic logic [31:0] negate(input logic [31:0] v);
    negate = 32'h0000_0000 - v;
  endfunction

  // ---------------------------------------------------------------
  // ALU
  // ---------------------------------------------------------------
  logic [31:0] acc;
  logic [31:0] operand_b;
  logic [32:0] sum;
  logic [31:0] next_acc;
  logic        next_carry;
  logic        next_ovf;

  always_comb begin
    // Right operand select
    operand_b = (i_src_sel == dalu_pkg::SRC_PRODUCT) ? i_product_holding_register  // [RL2]
                                                     : sh_bus.shifted;             // [RL2]
    sum        = 33'h0_0000_0000;
    next_carry = o_carry;
    next_ovf   = 1'b0;
    next_acc   = acc;
    // Left operand always accumulator, single cycle result
    unique case (dalu_pkg::dalu_op_type'(i_op))  // [RL1] [RL6]
      dalu_pkg::OP_LOAD: next_acc = operand_b;
      dalu_pkg::OP_ADD: begin
        sum        = {1'b0, acc} + {1'b0, operand_b};
        next_acc   = sum[31:0];
        next_carry = sum[32];
        next_ovf   = (acc[31] == operand_b[31]) && (sum[31] != acc[31]);
      end
      dalu_pkg::OP_SUB: begin
        sum        = {1'b0, acc} - {1'b0, operand_b};
        next_acc   = sum[31:0];
        next_carry = ~sum[32];
        next_ovf   = (acc[31] != operand_b[31]) && (sum[31] != acc[31]);
      end
      dalu_pkg::OP_AND:  next_acc = acc & operand_b;
      dalu_pkg::OP_OR:   next_acc = acc | operand_b;
      dalu_pkg::OP_XOR:  next_acc = acc ^ operand_b;
      dalu_pkg::OP_NEG: begin
        next_acc = negate(acc);
        next_ovf = (acc == 32'h8000_0000);
      end
      dalu_pkg::OP_ABS: begin
        next_acc = acc[31] ? negate(acc) : acc;
        next_ovf = (acc == 32'h8000_0000);
      end
      dalu_pkg::OP_CMPL: next_acc = ~acc;
      dalu_pkg::OP_NORM: next_acc = norm_step(acc);  // [RL8]
      dalu_pkg::OP_SFL: begin
        next_acc   = {acc[30:0], 1'b0};
        next_carry = acc[31];
      end
      dalu_pkg::OP_SFR: begin
        next_acc   = sign_extend_select_bit ? {acc[31], acc[31:1]} : {1'b0, acc[31:1]};  // [RL11]
        next_carry = acc[0];
      end
      dalu_pkg::OP_ZERO: next_acc = 32'h0000_0000;
      default:           next_acc = acc;
    endcase
  end

  // ---------------------------------------------------------------
  // Accumulator and flags
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc <= dalu_pkg::ACC_RESET;
    end else if (i_acc_write) begin  // [RL12]
      acc <= next_acc;  // [RL3]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_carry    <= 1'b0;
      o_overflow <= 1'b0;
      o_zero     <= 1'b1;
      o_negative <= 1'b0;
    end else if (i_acc_write) begin  // [RL12]
      o_carry    <= next_carry;
      o_overflow <= next_ovf;
      o_zero     <= is_zero(next_acc);
      o_negative <= next_acc[31];
    end
  end

  // Output copy of the accumulator, equal to it after every edge
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_acc <= dalu_pkg::ACC_RESET;
    end else begin
      o_acc <= i_acc_write ? next_acc : acc;
    end
  end

  // Low half of the accumulator as a program address
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_branch_target <= dalu_pkg::ACC_RESET[15:0];
    end else begin
      o_branch_target <= i_acc_write ? next_acc[15:0] : acc[15:0];  // [RL7]
    end
  end

  // ---------------------------------------------------------------
  // Store path
  // ---------------------------------------------------------------
  logic [31:0] store_shifted;

  always_comb begin
    // Shifted copy only; accumulator untouched
    store_shifted = acc << i_out_shift;  // [RL5]
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_store_data  <= 16'h0000;
      o_store_valid <= 1'b0;
    end else begin
      o_store_valid <= i_store;
      if (i_store) begin
        o_store_data <= i_store_high ? store_shifted[31:16] : store_shifted[15:0];  // [RL4] [RL5]
      end
    end
  end

  // ---------------------------------------------------------------
  // Bit test
  // ---------------------------------------------------------------
  // Bit select 0 picks the most significant bit
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bit_cond       <= 1'b0;
      o_bit_cond_valid <= 1'b0;
    end else begin
      o_bit_cond_valid <= i_bit_test;
      if (i_bit_test) begin
        o_bit_cond <= i_data_word[4'hf - i_bit_sel];  // [RL9]
      end
    end
  end

endmodule

/* core/dalu_pkg.sv */
// Package with operation codes, widths and field constants for the ALU/accumulator
package dalu_pkg;
  localparam int ACC_W    = 32;
  localparam int HALF_W   = 16;
  localparam int SHIFT_W  = 5;
  localparam int BIT_W    = 4;
  localparam int OP_W     = 4;
  localparam int NORM_W   = 5;
  localparam logic [4:0] MAX_IN_SHIFT  = 5'h10;
  localparam logic [2:0] MAX_OUT_SHIFT = 3'h7;
  localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
  localparam logic [15:0] SXM_BIT_POS  = 16'h000a;

  typedef enum logic [3:0] {
    OP_LOAD = 4'h0,
    OP_ADD  = 4'h1,
    OP_SUB  = 4'h2,
    OP_AND  = 4'h3,
    OP_OR   = 4'h4,
    OP_XOR  = 4'h5,
    OP_NEG  = 4'h6,
    OP_ABS  = 4'h7,
    OP_CMPL = 4'h8,
    OP_NORM = 4'h9,
    OP_SFL  = 4'ha,
    OP_SFR  = 4'hb,
    OP_ZERO = 4'hc
  } dalu_op_type;

  typedef enum logic [1:0] {
    SRC_SHIFTER = 2'h0,
    SRC_PRODUCT = 2'h1
  } dalu_src_type;
endpackage

/* core/dalu_shift_if.sv */
// Interface between accumulator core and input scaling shifter
`timescale 1ns/1ps
interface dalu_shift_if;
  logic [15:0] data_word;
  logic [4:0]  shift_amt;
  logic        sign_ext;
  logic [31:0] shifted;
  modport core  (output data_word, output shift_amt, output sign_ext, input shifted);
  modport shift (input data_word, input shift_amt, input sign_ext, output shifted);
endinterface

/* core/dalu_in_shifter.sv */
// Input scaling shifter: 16-bit word to 32-bit left-shifted operand
`timescale 1ns/1ps
module dalu_in_shifter (
  dalu_shift_if.shift sh
);
  logic [31:0] ext_word;
  logic [4:0]  amt;

  always_comb begin
    // Upper fill follows the sign-extension mode bit
    ext_word = sh.sign_ext ? {{16{sh.data_word[15]}}, sh.data_word}  // [RL11]
                           : {16'h0000, sh.data_word};               // [RL11]
    amt = (sh.shift_amt > dalu_pkg::MAX_IN_SHIFT) ? dalu_pkg::MAX_IN_SHIFT : sh.shift_amt;
    sh.shifted = ext_word << amt;  // [RL10]
  end
endmodule

/* sim/dalu_chk_sva.sv */
// Port assertions for the ALU accumulator block
`timescale 1ns/1ps
module dalu_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_arst_n,
  input wire logic        i_acc_write,
  input wire logic [3:0]  i_op,
  input wire logic [1:0]  i_src_sel,
  input wire logic [31:0] i_product_holding_register,
  input wire logic        i_store,
  input wire logic        i_store_high,
  input wire logic [2:0]  i_out_shift,
  input wire logic [31:0] o_acc,
  input wire logic [15:0] o_branch_target,
  input wire logic [15:0] o_store_data,
  input wire logic        o_store_valid
);
  logic [15:0] half;
  logic        wr_p;
  assign half = 16'((o_acc << i_out_shift) >> (i_store_high ? 16 : 0));
  assign wr_p = i_acc_write && i_src_sel == 2'h1;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  chk_acc_hold: assert property (!i_acc_write |=> $stable(o_acc))
    else $error("acc moved");
  chk_load_prod: assert property (wr_p && i_op == 4'h0 |=> o_acc == $past(i_product_holding_register))
    else $error("load wrong");
  chk_add_prod: assert property (wr_p && i_op == 4'h1 |=>
    o_acc == $past(o_acc) + $past(i_product_holding_register)) else $error("add wrong");
  chk_sub_prod: assert property (wr_p && i_op == 4'h2 |=>
    o_acc == $past(o_acc) - $past(i_product_holding_register)) else $error("sub wrong");
  chk_branch_tgt: assert property (o_branch_target == o_acc[15:0])
    else $error("branch target wrong");
  chk_store_half: assert property (i_store |=> o_store_valid && o_store_data == $past(half))
    else $error("store wrong");
  chk_store_idle: assert property (!i_store |=> !o_store_valid)
    else $error("store pulse wrong");
  chk_norm_step: assert property (i_acc_write && i_op == 4'h9 && o_acc[31] == o_acc[30] && o_acc != 32'h0 |=>
    o_acc == $past(o_acc) << 1) else $error("norm wrong");
  cover property (i_store && i_store_high);
  cover property (wr_p && i_op == 4'h1);
  cover property (i_acc_write && i_op == 4'h9);
endmodule
bind dalu_top dalu_chk u_chk (
  .i_sys_clk                  (i_sys_clk),
  .i_arst_n                   (i_arst_n),
  .i_acc_write                (i_acc_write),
  .i_op                       (i_op),
  .i_src_sel                  (i_src_sel),
  .i_product_holding_register (i_product_holding_register),
  .i_store                    (i_store),
  .i_store_high               (i_store_high),
  .i_out_shift                (i_out_shift),
  .o_acc                      (o_acc),
  .o_branch_target            (o_branch_target),
  .o_store_data               (o_store_data),
  .o_store_valid              (o_store_valid)
);

/* sim/dalu_bus_model.sv */
// Data bus and multiplier model: operand words by address
`timescale 1ns/1ps
module dalu_bus_model (
  input  wire logic [1:0]  i_addr,
  output logic      [15:0] o_data_word,
  output logic      [31:0] o_product
);
  always_comb begin
    case (i_addr)
      2'h0:    {o_data_word, o_product} = {16'h8001, 32'h1234_5678};
      2'h1:    {o_data_word, o_product} = {16'h00f0, 32'h0000_1000};
      default: {o_data_word, o_product} = {16'h7fff, 32'hffff_fff0};
    endcase
  end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the ALU accumulator block
`timescale 1ns/1ps
module tb_top;
  logic        i_sys_clk = 1'b0, i_arst_n = 1'b0, i_acc_write = 1'b0, i_store = 1'b0, i_store_high = 1'b0;
  logic        i_bit_test = 1'b0, o_store_valid, o_bit_cond, o_bit_cond_valid;
  logic        o_carry, o_overflow, o_zero, o_negative;
  logic [1:0]  i_src_sel = 2'h0, bus_addr = 2'h0;
  logic [2:0]  i_out_shift = 3'h0;
  logic [3:0]  i_op = 4'h0, i_bit_sel = 4'h0;
  logic [4:0]  i_in_shift = 5'h00;
  logic [15:0] i_second_status_register = 16'h0000, i_data_word, o_branch_target, o_store_data;
  logic [31:0] i_product_holding_register, o_acc;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  dalu_bus_model bus_u (.i_addr(bus_addr), .o_data_word(i_data_word), .o_product(i_product_holding_register));
  dalu_top dut_u (
    .i_sys_clk                  (i_sys_clk),
    .i_arst_n                   (i_arst_n),
    .i_acc_write                (i_acc_write),
    .i_op                       (i_op),
    .i_src_sel                  (i_src_sel),
    .i_data_word                (i_data_word),
    .i_in_shift                 (i_in_shift),
    .i_product_holding_register (i_product_holding_register),
    .i_second_status_register   (i_second_status_register),
    .i_store                    (i_store),
    .i_store_high               (i_store_high),
    .i_out_shift                (i_out_shift),
    .i_bit_test                 (i_bit_test),
    .i_bit_sel                  (i_bit_sel),
    .o_acc                      (o_acc),
    .o_branch_target            (o_branch_target),
    .o_store_data               (o_store_data),
    .o_store_valid              (o_store_valid),
    .o_bit_cond                 (o_bit_cond),
    .o_bit_cond_valid           (o_bit_cond_valid),
    .o_carry                    (o_carry),
    .o_overflow                 (o_overflow),
    .o_zero                     (o_zero),
    .o_negative                 (o_negative)
  );
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One write cycle, then check the accumulator
  task automatic alu(input logic [3:0] op, input logic [1:0] src, input logic [1:0] a, input logic [4:0] sh,
                     input logic sx, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_acc_write <= 1'b1;
    i_op <= op;
    i_src_sel <= src;
    bus_addr <= a;
    i_in_shift <= sh;
    i_second_status_register <= {5'h00, sx, 10'h000};
    @(posedge i_sys_clk);
    i_acc_write <= 1'b0;
    #1;
    chk("acc", e, o_acc);
    chk("zero neg", {30'h0, e == 32'h0000_0000, e[31]}, {30'h0, o_zero, o_negative});
  endtask
  // Store of one half together with a bit test
  task automatic io(input logic hi, input logic [2:0] sh, input logic [3:0] sel, input logic [15:0] ed, input logic eb);
    @(posedge i_sys_clk);
    i_store <= 1'b1;
    i_store_high <= hi;
    i_out_shift <= sh;
    i_bit_test <= 1'b1;
    i_bit_sel <= sel;
    @(posedge i_sys_clk);
    i_store <= 1'b0;
    i_bit_test <= 1'b0;
    #1;
    chk("store", {16'h0001, ed}, {15'h0000, o_store_valid, o_store_data});
    chk("bit", {30'h0, 1'b1, eb}, {30'h0, o_bit_cond_valid, o_bit_cond});
  endtask
  // Logic, negate, absolute, complement and shift codes in a chain
  task automatic logic_ops;
    alu(4'h4, 2'h1, 2'h0, 5'h00, 1'b0, 32'h1234_7678);
    alu(4'h3, 2'h0, 2'h2, 5'h04, 1'b0, 32'h0004_7670);
    alu(4'h5, 2'h1, 2'h2, 5'h00, 1'b0, 32'hfffb_8980);
    alu(4'h7, 2'h0, 2'h0, 5'h00, 1'b0, 32'h0004_7680);
    alu(4'h6, 2'h0, 2'h0, 5'h00, 1'b0, 32'hfffb_8980);
    alu(4'hb, 2'h0, 2'h0, 5'h00, 1'b1, 32'hfffd_c4c0);
    alu(4'h8, 2'h0, 2'h0, 5'h00, 1'b0, 32'h0002_3b3f);
    alu(4'ha, 2'h0, 2'h0, 5'h00, 1'b0, 32'h0004_767e);
    alu(4'hc, 2'h0, 2'h0, 5'h00, 1'b0, 32'h0000_0000);
  endtask
  // Signed overflow on an add of two positive operands
  task automatic add_overflow;
    alu(4'h0, 2'h0, 2'h2, 5'h10, 1'b0, 32'h7fff_0000);
    alu(4'h1, 2'h0, 2'h2, 5'h10, 1'b0, 32'hfffe_0000);
    chk("carry ovf", 32'h0000_0001, {30'h0, o_carry, o_overflow});
  endtask
  // Reset in mid-run, then work resumes
  task automatic mid_reset;
    @(posedge i_sys_clk);
    i_arst_n <= 1'b0;
    #1;
    chk("reset acc", 32'h0000_0000, o_acc);
    chk("reset outs", 32'h0000_0004, {13'h0000, o_branch_target, o_zero, o_store_valid, o_bit_cond_valid});
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    alu(4'h0, 2'h1, 2'h1, 5'h00, 1'b0, 32'h0000_1000);
  endtask
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    alu(4'h0, 2'h1, 2'h0, 5'h00, 1'b0, 32'h1234_5678);
    alu(4'h1, 2'h1, 2'h2, 5'h00, 1'b0, 32'h1234_5668);
    chk("carry ovf", 32'h0000_0002, {30'h0, o_carry, o_overflow});
    alu(4'h2, 2'h1, 2'h1, 5'h00, 1'b0, 32'h1234_4668);
    chk("branch", 32'h0000_4668, {16'h0000, o_branch_target});
    io(1'b1, 3'h0, 4'h8, 16'h1234, 1'b1);
    io(1'b0, 3'h4, 4'h0, 16'h6680, 1'b0);
    chk("acc kept", 32'h1234_4668, o_acc);
    alu(4'h0, 2'h0, 2'h0, 5'h04, 1'b1, 32'hfff8_0010);
    alu(4'h0, 2'h0, 2'h0, 5'h10, 1'b0, 32'h8001_0000);
    alu(4'h0, 2'h1, 2'h1, 5'h00, 1'b0, 32'h0000_1000);
    alu(4'h9, 2'h0, 2'h1, 5'h00, 1'b0, 32'h0000_2000);
    logic_ops();
    add_overflow();
    mid_reset();
    stop_test();
  end
endmodule
